// ===== crc16_defs.svh
// Register offsets, field positions, reset values and polynomial constants
`ifndef CRC16_DEFS_SVH
`define CRC16_DEFS_SVH
`define CRC_OFF_GENERATOR_SELECT_CONTROL 12'h000
`define CRC_OFF_BYTE_INPUT 12'h004
`define CRC_OFF_SUM_LOW 12'h008
`define CRC_OFF_SUM_HIGH 12'h00C
`define CRC_ADDR_MSB 11
`define CRC_SEL_BIT 0
`define CRC_GENERATOR_SELECT_CCITT 16'h1021
`define CRC_GENERATOR_SELECT_16 16'h8005
`define CRC_RESET_BYTE 8'h00
`define CRC_RESET_SUM 16'h0000
`define CRC_RESET_WORD 32'h0000_0000
`define CRC_READY_IDLE 1'b1
`define CRC_RESP_OKAY 1'b0
`define CRC_BYTE_BITS 8
`define CRC_HTRANS_NONSEQ_BIT 1
`endif

// ===== crc16_pkg.sv
// Types shared by the checksum block
package crc16_pkg;
  typedef enum logic {
    gen_ccitt,
    gen_crc16
  } generator_t;
  typedef enum logic [1:0] {
    reg_generator_select,
    reg_input,
    reg_low,
    reg_high
  } reg_sel_t;
endpackage

// ===== crc16_byte_step.sv
// Combinational eight-step fold of one byte into the running checksum
`timescale 1ns/1ps
`include "crc16_defs.svh"
module crc16_byte_step (
  input wire logic [15:0] sum_in,
  input wire logic [7:0] data_in,
  input wire crc16_pkg::generator_t gen_sel,
  output logic [15:0] sum_out
);
  function automatic logic [15:0] bit_step(input logic [15:0] v, input logic [15:0] generator_select);
    logic [15:0] sh;
    sh = {v[14:0], 1'b0}; // RULE_05
    bit_step = v[15] ? (sh ^ generator_select) : sh; // RULE_06
  endfunction

  wire [15:0] generator_select_w = (gen_sel == crc16_pkg::gen_crc16) ? `CRC_GENERATOR_SELECT_16 : `CRC_GENERATOR_SELECT_CCITT; // RULE_01
  wire [15:0] temp_w = sum_in ^ {data_in, 8'h00}; // RULE_04

  always_comb begin
    sum_out = temp_w;
    for (int i = 0; i < `CRC_BYTE_BITS; i++) begin
      sum_out = bit_step(sum_out, generator_select_w); // RULE_07
    end
  end
endmodule

// ===== crc16_addr_decode.sv
// Word address decode for the four checksum registers
`timescale 1ns/1ps
`include "crc16_defs.svh"
module crc16_addr_decode (
  input wire logic [31:0] addr,
  output logic hit,
  output crc16_pkg::reg_sel_t sel
);
  wire [11:0] off_w = addr[`CRC_ADDR_MSB:0];
  assign hit = (off_w == `CRC_OFF_GENERATOR_SELECT_CONTROL) || (off_w == `CRC_OFF_BYTE_INPUT)
            || (off_w == `CRC_OFF_SUM_LOW) || (off_w == `CRC_OFF_SUM_HIGH);
  assign sel = (off_w == `CRC_OFF_BYTE_INPUT) ? crc16_pkg::reg_input :
               (off_w == `CRC_OFF_SUM_LOW) ? crc16_pkg::reg_low :
               (off_w == `CRC_OFF_SUM_HIGH) ? crc16_pkg::reg_high : crc16_pkg::reg_generator_select;
endmodule

// ===== byte_crc16_generator.sv
// Byte-wide 16-bit checksum generator behind an AHB-Lite slave
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "crc16_defs.svh"
// What this block does and what software must do
// RULE_01: Bit 0 of the control register picks CCITT (0) or CRC-16 (1) as generator.
// RULE_02: Each byte written to the input register folds once into the stored checksum pair.
// RULE_03: The new checksum is in the pair one clock after the write data phase.
// RULE_04: An update starts by XORing the input byte into the checksum high byte.
// RULE_05: Each bit step shifts the temporary value left one place with a zero in.
// RULE_06: After the shift a one leaving the top bit XORs in 8005h or 1021h.
// RULE_07: Eight such bit steps are done per byte before the result is stored.
// RULE_08: Software clears both checksum bytes before starting a new block.
// RULE_09: The checksum is two separately readable and writable 8-bit registers.
// RULE_10: Control bits 7 to 1 read as zero and ignore writes.
// RULE_11: For program words software selects the generator, then writes low byte before high.
// RULE_12: Writing a checksum byte replaces it directly and triggers no update.
module byte_crc16_generator (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  // Bus capture: an accepted write waits here for its data phase
  logic wr_pend_q;
  logic wr_pend_d;
  crc16_pkg::reg_sel_t wr_sel_q;
  crc16_pkg::reg_sel_t wr_sel_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic hreadyout_q;
  logic hreadyout_d;
  logic hresp_q;
  logic hresp_d;

  // Software-visible state, the checksum kept as two byte registers
  crc16_pkg::generator_t generator_select_q;
  crc16_pkg::generator_t generator_select_d;
  logic [7:0] byte_input_q;
  logic [7:0] byte_input_d;
  logic [7:0] sum_high_q;
  logic [7:0] sum_high_d;
  logic [7:0] sum_low_q;
  logic [7:0] sum_low_d;
  logic [15:0] running_checksum_q;

  logic hit_w;
  crc16_pkg::reg_sel_t sel_w;
  logic [15:0] folded_w;
  logic [31:0] rd_d;
  logic wr_generator_select;
  logic wr_input;
  logic wr_low;
  logic wr_high;
  logic [7:0] wr_byte;
  logic sel_bit;

  function automatic logic [31:0] byte_word(
    input logic [7:0] b
  );
    byte_word = {24'h00_0000, b};
  endfunction

  function automatic logic strobe_for(
    input logic pend,
    input crc16_pkg::reg_sel_t held,
    input crc16_pkg::reg_sel_t which
  );
    strobe_for = pend && (held == which);
  endfunction

  function automatic logic [7:0] merge_byte(
    input logic [7:0] old_byte,
    input logic [7:0] new_byte,
    input logic take
  );
    merge_byte = take ? new_byte : old_byte;
  endfunction

  function automatic logic [31:0] read_mux(
    input crc16_pkg::reg_sel_t s,
    input crc16_pkg::generator_t g,
    input logic [7:0] in_byte,
    input logic [7:0] high_byte,
    input logic [7:0] low_byte
  );
    logic [7:0] flag_byte;
    flag_byte = {7'h00, g == crc16_pkg::gen_crc16}; // RULE_10
    case (s)
      crc16_pkg::reg_generator_select: begin
        read_mux = byte_word(flag_byte);
      end
      crc16_pkg::reg_input: begin
        read_mux = byte_word(in_byte);
      end
      crc16_pkg::reg_low: begin
        read_mux = byte_word(low_byte); // RULE_09
      end
      crc16_pkg::reg_high: begin
        read_mux = byte_word(high_byte); // RULE_09
      end
      default: begin
        read_mux = `CRC_RESET_WORD;
      end
    endcase
  endfunction

  // Whole-word singles only; hsize is accepted as the master promises
  wire addr_phase = hsel && hready && htrans[`CRC_HTRANS_NONSEQ_BIT];
  wire wr_take = addr_phase && hwrite && hit_w;
  wire rd_take = addr_phase && !hwrite && hit_w;

  crc16_addr_decode crc16_addr_decode_inst (
    .addr(haddr),
    .hit(hit_w),
    .sel(sel_w)
  );

  crc16_byte_step crc16_byte_step_inst (
    .sum_in(running_checksum_q),
    .data_in(wr_byte),
    .gen_sel(generator_select_q),
    .sum_out(folded_w)
  );

  assign wr_generator_select = strobe_for(wr_pend_q, wr_sel_q, crc16_pkg::reg_generator_select);
  assign wr_input = strobe_for(wr_pend_q, wr_sel_q, crc16_pkg::reg_input);
  assign wr_low = strobe_for(wr_pend_q, wr_sel_q, crc16_pkg::reg_low);
  assign wr_high = strobe_for(wr_pend_q, wr_sel_q, crc16_pkg::reg_high);
  assign wr_byte = hwdata[7:0];
  assign sel_bit = hwdata[`CRC_SEL_BIT];

  assign wr_pend_d = wr_take;
  assign wr_sel_d = wr_take
                  ? sel_w
                  : wr_sel_q;
  assign generator_select_d = wr_generator_select
                            ? crc16_pkg::generator_t'(sel_bit) // RULE_01
                            : generator_select_q;
  assign byte_input_d = merge_byte(byte_input_q, wr_byte, wr_input);
  // A fold rewrites both bytes; a direct byte write seeds one and folds nothing
  assign sum_high_d = wr_input
                    ? folded_w[15:8] // RULE_02 RULE_03
                    : merge_byte(sum_high_q, wr_byte, wr_high); // RULE_12
  assign sum_low_d = wr_input
                   ? folded_w[7:0] // RULE_02 RULE_03
                   : merge_byte(sum_low_q, wr_byte, wr_low); // RULE_12
  assign running_checksum_q = {sum_high_q, sum_low_q};

  // Reads see this edge's next values, so a read in a write's data phase is never stale
  assign rd_d = read_mux(
    sel_w,
    generator_select_d,
    byte_input_d,
    sum_high_d,
    sum_low_d
  );
  assign hrdata_d = rd_take
                  ? rd_d
                  : (addr_phase ? `CRC_RESET_WORD : hrdata_q);
  // The fold settles in one clock, so the slave never stalls
  assign hreadyout_d = `CRC_READY_IDLE; // RULE_03
  assign hresp_d = `CRC_RESP_OKAY;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= wr_pend_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_sel_q <= crc16_pkg::reg_generator_select;
    end else begin
      wr_sel_q <= wr_sel_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= `CRC_RESET_WORD;
    end else begin
      hrdata_q <= hrdata_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= `CRC_READY_IDLE;
    end else begin
      hreadyout_q <= hreadyout_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_q <= `CRC_RESP_OKAY;
    end else begin
      hresp_q <= hresp_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      generator_select_q <= crc16_pkg::gen_ccitt;
    end else begin
      generator_select_q <= generator_select_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      byte_input_q <= `CRC_RESET_BYTE;
    end else begin
      byte_input_q <= byte_input_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sum_high_q <= `CRC_RESET_BYTE;
    end else begin
      sum_high_q <= sum_high_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sum_low_q <= `CRC_RESET_BYTE;
    end else begin
      sum_low_q <= sum_low_d;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
endmodule

// ===== crc_chk.sv
// Bus and register checks for the checksum block
`timescale 1ns/1ps
module crc_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  logic r_q, w_q, c_q, u_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk) {r_q, w_q, c_q, u_q} <= {hsel && hready && htrans[1] && !hwrite,
    hsel && hready && htrans[1] && hwrite, haddr[11:0] == 12'h000, haddr[11:0] > 12'h00c || haddr[1:0] != 2'h0};
  a_ready_high: assert property (hreadyout) else $error("wait state");
  a_resp_okay: assert property (!hresp) else $error("bad response");
  a_upper_zero: assert property (hrdata[31:8] == '0) else $error("upper bits");
  a_ctrl_read: assert property (r_q && c_q |-> hrdata[31:1] == '0) else $error("control bits");
  a_unmapped_zero: assert property (r_q && u_q |-> hrdata == '0) else $error("unmapped data");
  a_write_clear: assert property (w_q |-> hrdata == '0) else $error("write data");
  a_data_hold: assert property (!r_q && !w_q |-> $stable(hrdata)) else $error("data moved");
  a_reset_clear: assert property ($rose(hresetn) |-> hrdata == '0) else $error("reset data");
  c_sum_read: cover property (r_q && !c_q && !u_q);
  c_ctrl_write: cover property (w_q && c_q);
  c_unmapped: cover property (r_q && u_q);
endmodule
bind byte_crc16_generator crc_chk crc_chk_inst (.*);

// ===== byte_crc16_generator_bench.sv
// Random and corner-case bench for the checksum block
`timescale 1ns/1ps
module byte_crc16_generator_bench;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, blk;
  logic [15:0] e;
  int mismatches = 0, samples_checked = 0, n;
  always #2 hclk = ~hclk;
  assign hready = hreadyout;
  byte_crc16_generator byte_crc16_generator_inst (.*);
  function automatic logic [15:0] fold(logic [15:0] s, logic g);
    repeat (8) s = {s[14:0], 1'b0} ^ (s[15] ? (g ? 16'h8005 : 16'h1021) : 16'h0000);
    return s;
  endfunction
  task automatic test_done(input int t);
    mismatches += t;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    {hsel, htrans, haddr, hwrite} <= {3'h6, 20'h0_0000, a, w};
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
      if (n >= 50) test_done(1);
      if (k == 0) {htrans, hwdata} <= {2'h0, d};
    end
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [31:0] x);
    bus(1'b0, a, '0);
    samples_checked++;
    mismatches += int'(hrdata !== x);
    if (hrdata !== x) $display("mismatch t=%0t exp=%h got=%h", $time, x, hrdata);
  endtask
  initial begin
    void'($urandom(32'h0000_555e));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 5; i++) chk_rd(12'(4 * i), '0);
    for (int i = 0; i < 40; i++) begin
      e = i < 18 ? 16'h0000 : 16'($urandom);
      blk = i < 16 ? 32'(i / 2) : i < 18 ? 32'h1234_5678 : $urandom;
      bus(1'b1, 12'h000, {31'($urandom), i[0]});
      bus(1'b1, 12'h008, 32'(e[7:0]));
      bus(1'b1, 12'h00c, 32'(e[15:8]));
      repeat (i < 16 ? 1 : 4) begin
        bus(1'b1, 12'h004, 32'(blk[7:0]));
        e = fold(e ^ {blk[7:0], 8'h00}, i[0]);
        blk >>= 8;
      end
      chk_rd(12'h000, 32'(i[0]));
      chk_rd(12'h00c, 32'(e[15:8]));
      chk_rd(12'h008, 32'(e[7:0]));
    end
    // Mid-run reset must bring every register back to zero
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 4; i++) chk_rd(12'(4 * i), '0);
    test_done(0);
  end
endmodule
